/* hdl/adc_seq_pkg.sv */
package adc_seq_pkg;

    // Register byte addresses (one aligned word each)
    localparam logic [11:0] CTRL_A_ADDR = 12'h000;
    localparam logic [11:0] CTRL_B_ADDR = 12'h004;
    localparam logic [11:0] INT_CTRL_ADDR = 12'h008;
    localparam logic [11:0] RESULT_HIGH_ADDR = 12'h00c;
    localparam logic [11:0] RESULT_LOW_ADDR = 12'h010;
    localparam logic [11:0] ANALOG_DATA_ADDR = 12'h014;

    // Control register a field positions
    localparam int CHAN_LSB = 0;
    localparam int FORMAT_BIT = 4;
    localparam int POWER_BIT = 5;
    localparam int BUSY_BIT = 6;
    localparam int START_BIT = 7;

    // Control register b field positions
    localparam int DIV_LSB = 0;
    localparam int REF_LSB = 3;
    localparam int SRC_LSB = 5;

    // Interrupt control field positions
    localparam int GIE_BIT = 0;
    localparam int AIE_BIT = 1;
    localparam int FLAG_BIT = 2;

    // Conversion timing in converter clock cycles
    localparam int SAMPLE_CYCLES = 4;
    localparam int CONVERT_CYCLES = 12;
    localparam int TOTAL_CYCLES = SAMPLE_CYCLES + CONVERT_CYCLES;

    // Source select codes
    localparam logic [2:0] SRC_BANDGAP = 3'h1;
    localparam logic [2:0] SRC_GND_LO = 3'h2;
    localparam logic [2:0] SRC_GND_HI = 3'h4;

    // Routing choice driven to the analog core
    typedef enum logic [1:0] {
        ROUTE_EXTERNAL = 2'h0,
        ROUTE_BANDGAP = 2'h1,
        ROUTE_GROUND = 2'h2
    } route_t;

    // Configuration bundle to the analog core
    typedef struct packed {
        logic power_on;
        route_t route;
        logic [3:0] channel;
        logic [1:0] reference;
        logic sample;
        logic convert;
    } analog_ctrl_t;

endpackage

/* hdl/adc_clock_divider.sv */
`timescale 1ns/1ps
// Power-of-two tick generator for the converter clock
module adc_clock_divider #(
    parameter int SEL_W = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [SEL_W-1:0] sel,
    output logic tick
);
    localparam int CNT_W = (1 << SEL_W) - 1;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] limit;

    // Terminal count is two to the sel, minus one
    always_comb begin
        limit = CNT_W'((1 << sel) - 1);
        if (!run || cnt_reg >= limit) begin
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
        tick = run && (cnt_reg >= limit);
    end

    // Counter register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

/* hdl/adc_conversion_sequencer.sv */
`timescale 1ns/1ps
module adc_conversion_sequencer
    import adc_seq_pkg::*;
#(
    parameter int RES_W = 12,
    parameter int DIV_W = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [RES_W-1:0] analog_result,
    output analog_ctrl_t analog_ctrl,
    output logic irq
);

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } seq_state_t;

    // Software-visible control state
    // Channel code handed to the input mux
    logic [3:0] channel_reg, channel_next;
    // Result alignment choice
    logic format_reg, format_next;
    // Analog power request
    logic power_reg, power_next;
    // Last written start bit; its falling write is the trigger
    logic start_reg, start_next;
    // Converter clock division code
    logic [DIV_W-1:0] div_reg, div_next;
    // Reference voltage choice
    logic [1:0] ref_reg, ref_next;
    // Input source code
    logic [2:0] src_reg, src_next;
    // Global interrupt enable
    logic gie_reg, gie_next;
    // Converter interrupt enable
    logic aie_reg, aie_next;
    // Completion request, sticky until software writes 0
    logic flag_reg, flag_next;
    // Conversion state
    seq_state_t state_reg, state_next;
    // Converter ticks elapsed in this conversion
    logic [4:0] cyc_reg, cyc_next;
    // Result bytes; held until the next completion
    logic [7:0] high_reg, high_next;
    logic [7:0] low_reg, low_next;
    // Bus answer registers
    // Read data, held between accesses
    logic [31:0] prdata_reg, prdata_next;
    // One-cycle answer strobe and its error flag
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    // Interrupt line, registered so the pin never glitches
    logic irq_reg, irq_next;
    // Analog core configuration
    analog_ctrl_t actrl_reg, actrl_next;

    // Converter clock enable pulse
    logic tick;
    // Setup phase of a bus transfer
    logic setup_ph;
    // Write lands in this cycle
    logic wr_en;
    // Last converter tick of a conversion
    logic done;
    // Conversion in flight
    logic busy;
    // Address maps to a register
    logic hit;

    assign busy = (state_reg != ST_IDLE);

    // Converter clock tick; runs only while sampling or converting
    adc_clock_divider #(
        .SEL_W(DIV_W)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(busy),
        .sel(div_reg),
        .tick(tick)
    );

    // Slave answers in the cycle after setup, so access is always one cycle
    assign setup_ph = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready_reg;

    // Address decode
    always_comb begin
        case (paddr)
            CTRL_A_ADDR, CTRL_B_ADDR, INT_CTRL_ADDR,
            RESULT_HIGH_ADDR, RESULT_LOW_ADDR: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Register writes and conversion sequencing
    always_comb begin
        channel_next = channel_reg;
        format_next = format_reg;
        power_next = power_reg;
        start_next = start_reg;
        div_next = div_reg;
        ref_next = ref_reg;
        src_next = src_reg;
        gie_next = gie_reg;
        aie_next = aie_reg;
        flag_next = flag_reg;
        state_next = state_reg;
        cyc_next = cyc_reg;
        high_next = high_reg;
        low_next = low_reg;
        done = 1'b0;
        if (wr_en) begin
            case (paddr)
                // Start bit is kept so the falling write can be seen
                CTRL_A_ADDR: begin
                    channel_next = pwdata[CHAN_LSB +: 4];
                    format_next = pwdata[FORMAT_BIT];
                    power_next = pwdata[POWER_BIT];
                    start_next = pwdata[START_BIT];
                end
                // Clock, reference and source codes
                CTRL_B_ADDR: begin
                    div_next = pwdata[DIV_LSB +: DIV_W];
                    ref_next = pwdata[REF_LSB +: 2];
                    src_next = pwdata[SRC_LSB +: 3];
                end
                // Enables, and the flag cleared by writing 0
                INT_CTRL_ADDR: begin
                    gie_next = pwdata[GIE_BIT];
                    aie_next = pwdata[AIE_BIT];
                    flag_next = pwdata[FLAG_BIT];
                end
                default: begin
                    // Result bytes and unmapped offsets ignore writes
                end
            endcase
        end
        case (state_reg)
            ST_IDLE: begin
                // Falling edge of start ends the pulse; power must be on
                if (start_reg && !start_next && power_reg) begin
                    state_next = ST_SAMPLE;
                    cyc_next = '0;
                end
            end
            ST_SAMPLE: begin
                if (tick) begin
                    cyc_next = cyc_reg + 5'h01;
                    if (cyc_reg == 5'(SAMPLE_CYCLES - 1)) begin
                        state_next = ST_CONVERT;
                    end
                end
            end
            ST_CONVERT: begin
                // Sixteenth tick closes the conversion
                if (tick) begin
                    cyc_next = cyc_reg + 5'h01;
                    if (cyc_reg == 5'(TOTAL_CYCLES - 1)) begin
                        done = 1'b1;
                        state_next = ST_IDLE;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // Power removal aborts a conversion in flight; the written value is
        // used so the core never sees a phase strobe with power already off
        if (!power_next) begin
            state_next = ST_IDLE;
        end
        if (done) begin
            // Both bytes land in the same edge busy drops
            if (format_reg) begin
                high_next = {4'h0, analog_result[11:8]};
                low_next = analog_result[7:0];
            end else begin
                high_next = analog_result[11:4];
                low_next = {analog_result[3:0], 4'h0};
            end
            flag_next = 1'b1; // set wins over a clearing write
        end
    end

    // Bus answer, interrupt and analog control outputs
    always_comb begin
        prdata_next = prdata_reg;
        pready_next = setup_ph;
        pslverr_next = 1'b0;
        if (setup_ph) begin
            pslverr_next = !hit;
            case (paddr)
                CTRL_A_ADDR: prdata_next = {24'h0, start_reg, busy, power_reg,
                    format_reg, channel_reg};
                CTRL_B_ADDR: prdata_next = 32'({src_reg, ref_reg, div_reg});
                INT_CTRL_ADDR: prdata_next = {29'h0, flag_reg, aie_reg, gie_reg};
                RESULT_HIGH_ADDR: prdata_next = {24'h0, high_reg};
                RESULT_LOW_ADDR: prdata_next = {24'h0, low_reg};
                // Unmapped offsets read as zero
                default: prdata_next = 32'h0;
            endcase
        end
        irq_next = flag_next && aie_next && gie_next;
        actrl_next.power_on = power_next;
        actrl_next.channel = channel_next;
        actrl_next.reference = ref_next;
        // Codes with no pin route from internal sources
        if (src_next == SRC_BANDGAP) begin
            actrl_next.route = ROUTE_BANDGAP;
        end else if (src_next >= SRC_GND_LO && src_next <= SRC_GND_HI) begin
            actrl_next.route = ROUTE_GROUND;
        end else begin
            actrl_next.route = ROUTE_EXTERNAL;
        end
        actrl_next.sample = (state_next == ST_SAMPLE);
        actrl_next.convert = (state_next == ST_CONVERT);
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_reg <= 4'h0;
            format_reg <= 1'b0;
            power_reg <= 1'b0;
            start_reg <= 1'b0;
            div_reg <= '0;
            ref_reg <= 2'h0;
            src_reg <= 3'h0;
            gie_reg <= 1'b0;
            aie_reg <= 1'b0;
            flag_reg <= 1'b0;
            state_reg <= ST_IDLE;
            cyc_reg <= 5'h00;
            high_reg <= 8'h00;
            low_reg <= 8'h00;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
            actrl_reg <= '0;
        end else begin
            channel_reg <= channel_next;
            format_reg <= format_next;
            power_reg <= power_next;
            start_reg <= start_next;
            div_reg <= div_next;
            ref_reg <= ref_next;
            src_reg <= src_next;
            gie_reg <= gie_next;
            aie_reg <= aie_next;
            flag_reg <= flag_next;
            state_reg <= state_next;
            cyc_reg <= cyc_next;
            high_reg <= high_next;
            low_reg <= low_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
            actrl_reg <= actrl_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign analog_ctrl = actrl_reg;

endmodule

/* verification/adc_seq_chk.sv */
`timescale 1ns/1ps
// Port-side watcher for the sequencer
module adc_seq_chk
    import adc_seq_pkg::*;
#(
    parameter int RES_W = 12,
    parameter int DIV_W = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [RES_W-1:0] analog_result,
    input wire analog_ctrl_t analog_ctrl,
    input wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Interrupt control write landing this cycle
    logic int_wr;
    assign int_wr = psel && penable && pready && pwrite && paddr == INT_CTRL_ADDR;
    // Cycles spent in the current phase, zero when idle
    int samp_cnt;
    int conv_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_cnt <= 0;
            conv_cnt <= 0;
        end else begin
            samp_cnt <= analog_ctrl.sample ? samp_cnt + 1 : 0;
            conv_cnt <= analog_ctrl.convert ? conv_cnt + 1 : 0;
        end
    end
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no answer");
    property p_access; pready |-> psel && penable ##1 !pready; endproperty
    a_access: assert property (p_access) else $error("bad access");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("bad refusal");
    property p_power; analog_ctrl.sample || analog_ctrl.convert |-> analog_ctrl.power_on;
    endproperty
    a_power: assert property (p_power) else $error("runs unpowered");
    property p_samp;
        $fell(analog_ctrl.sample) && analog_ctrl.power_on |-> analog_ctrl.convert && samp_cnt >= 4;
    endproperty
    a_samp: assert property (p_samp) else $error("short sample");
    property p_conv; $fell(analog_ctrl.convert) && analog_ctrl.power_on |-> conv_cnt >= 12;
    endproperty
    a_conv: assert property (p_conv) else $error("short convert");
    property p_irq_on; $rose(irq) |-> $fell(analog_ctrl.convert) || $past(int_wr); endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq rose");
    property p_irq_off; $fell(irq) |-> $past(int_wr); endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq fell");
    c_irq: cover property ($rose(irq));
    c_done: cover property ($fell(analog_ctrl.convert));
    c_err: cover property (pslverr);
endmodule
bind adc_conversion_sequencer adc_seq_chk #(.RES_W(RES_W), .DIV_W(DIV_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_result(analog_result), .analog_ctrl(analog_ctrl), .irq(irq));

/* verification/analog_core_model.sv */
`timescale 1ns/1ps
// Ideal analog core: the bench level is already the code
module analog_core_model
    import adc_seq_pkg::*;
#(
    parameter logic [11:0] BG_CODE = 12'h4d2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire analog_ctrl_t ctrl,
    input wire logic [11:0] level,
    output logic [11:0] result
);
    // Valid only while converting; scrambled otherwise so stale reads show
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= 12'h000;
        end else if (ctrl.power_on && ctrl.convert) begin
            result <= ctrl.route == ROUTE_EXTERNAL ? level :
                (ctrl.route == ROUTE_BANDGAP ? BG_CODE : 12'h000);
        end else begin
            result <= ~result;
        end
    end
endmodule

/* verification/adc_conversion_sequencer_tb.sv */
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
    import adc_seq_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [11:0] level = 12'h000;
    logic [31:0] prdata, rd, mid;
    logic pready, pslverr, irq, err_seen;
    logic [11:0] analog_result;
    analog_ctrl_t analog_ctrl;
    int errors = 0, samples_checked = 0, cycles = 0, samp_n = 0, conv_n = 0;
    always #5 pclk = ~pclk;
    adc_conversion_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .analog_result(analog_result), .analog_ctrl(analog_ctrl), .irq(irq));
    analog_core_model u_core (.pclk(pclk), .presetn(presetn), .ctrl(analog_ctrl),
        .level(level), .result(analog_result));
    // Phase lengths, and a watchdog well above the slow-divider run
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        samp_n <= samp_n + int'(analog_ctrl.sample);
        conv_n <= conv_n + int'(analog_ctrl.convert);
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One transfer; ends mid-cycle so registered outputs have settled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    // Start pulse, then poll busy; mid keeps the low byte seen mid-run
    task automatic convert(input logic [7:0] ctl);
        int n;
        n = 0;
        apb(1'b1, CTRL_A_ADDR, {24'h0, ctl | 8'h80});
        samp_n = 0;
        conv_n = 0;
        apb(1'b0, CTRL_A_ADDR, 32'h0);
        check(rd[BUSY_BIT], 1'b0);
        apb(1'b1, CTRL_A_ADDR, {24'h0, ctl});
        apb(1'b0, RESULT_LOW_ADDR, 32'h0);
        mid = rd;
        do apb(1'b0, CTRL_A_ADDR, 32'h0); while (rd[BUSY_BIT] === 1'b1 && ++n < 1000);
        check(n > 0 && n < 1000, 1'b1);
    endtask
    task automatic test_done();
        $display("Compared %0d, mismatched %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            check(rd, 32'h0);
        end
        apb(1'b0, 12'h018, 32'h0);
        check(err_seen, 1'b1);
        // Park the mux on a pinless channel before any internal source
        apb(1'b1, CTRL_A_ADDR, 32'h08);
        check(analog_ctrl.channel, 4'h8);
        // Every source code; the last one routes the external pin
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, CTRL_B_ADDR, 32'((s << SRC_LSB) | (2 << REF_LSB)));
            check(analog_ctrl.route, (s == 1) ? 1 : (s > 1 && s < 5) ? 2 : 0);
        end
        check(analog_ctrl.reference, 2'h2);
        // Start pulse while unpowered must not run
        apb(1'b1, CTRL_A_ADDR, 32'h83);
        apb(1'b1, CTRL_A_ADDR, 32'h03);
        apb(1'b0, CTRL_A_ADDR, 32'h0);
        check(rd, 32'h03);
        level = 12'habc;
        convert(8'h23);
        check(conv_n, 12);
        check(samp_n, 4);
        apb(1'b0, RESULT_HIGH_ADDR, 32'h0);
        check(rd, 32'hab);
        apb(1'b0, RESULT_LOW_ADDR, 32'h0);
        check(rd, 32'hc0);
        apb(1'b0, INT_CTRL_ADDR, 32'h0);
        check({rd[2:0], irq}, 4'h8);
        // Converter enable alone keeps the line quiet
        apb(1'b1, INT_CTRL_ADDR, 32'h2);
        level = 12'h5a3;
        convert(8'h33);
        check(irq, 1'b0);
        apb(1'b1, INT_CTRL_ADDR, 32'h7);
        check(irq, 1'b1);
        apb(1'b1, INT_CTRL_ADDR, 32'h3);
        check(irq, 1'b0);
        // Slowest divider; old bytes stand until completion
        apb(1'b1, CTRL_B_ADDR, 32'h7);
        level = 12'h123;
        convert(8'h33);
        check(mid, 32'ha3);
        check(conv_n, 12 * 128);
        check(samp_n > 3 * 128 && samp_n <= 4 * 128, 1'b1);
        check(irq, 1'b1);
        apb(1'b1, RESULT_HIGH_ADDR, 32'hff);
        apb(1'b0, RESULT_HIGH_ADDR, 32'h0);
        check(rd, 32'h01);
        // Power dropped mid-run: no result
        apb(1'b1, CTRL_A_ADDR, 32'hb3);
        apb(1'b1, CTRL_A_ADDR, 32'h33);
        apb(1'b1, CTRL_A_ADDR, 32'h13);
        check(analog_ctrl.power_on, 1'b0);
        apb(1'b0, RESULT_LOW_ADDR, 32'h0);
        check(rd, 32'h23);
        test_done();
    end
endmodule
